// ---- hw/sfp_pin_roles.v ----
// pin-role logic of a multi-line serial flash
`timescale 1ns/100ps
`include "sfp_defines.vh"

// Operation
// - single-line read data leaves on line 1, changed on clock fall
// - dual/quad input programs sample line 1 as input on clock rise
// - dual protocol makes line 1 bidirectional in every phase
// - quad lines bidirectional; accelerated modify falls back to single until supply low
// - line 2 is data in quad protocol or quad reads and quad programs in single
// - input receivers enabled except while that line is driven
// - line 3 as quad data ignores pause and reset while selected
// - reset pin low resets the enhanced register, double-rate flag and acceleration state, and floats all outputs
// - pause floats output and ignores input data and clock
// - quad reads and quad programs use pause pin as data
// - quad protocol: line 3 data when selected, reset when deselected
// - configuration bit 4 of either register disables pause
// - a double-rate operation disables pause
// - single/dual commands: write-protect low locks block-protect region
// - write-protect pin is line 2 in quad reads, quad programs and quad protocol
// - supply acceleration only while enhanced bit 3 is 0
// - enhanced bit 3 resets to 1
// - supply line is data until last input; 200 ms wait else slow
// - chip select high floats outputs; first fall needed before commands
// - inputs sampled on clock rise, outputs shifted on clock fall
module sfp_pin_roles #(
    parameter [31:0] ACC_WAIT_CYC = `SFP_ACC_WAIT_MS * `SFP_CLK_KHZ,
    parameter        RST_CAPABLE  = 1
) (
    input  wire       I_CLOCK,
    input  wire       I_RST_N,
    input  wire       I_SCLK,
    input  wire       I_CS_N,
    input  wire       I_RESET_PIN_N,
    input  wire       I_VPP_HIGH,
    input  wire [3:0] I_DQ_IN,
    input  wire [1:0] I_PROTO,
    input  wire [2:0] I_CMD_CLASS,
    input  wire       I_OUT_PHASE,
    input  wire       I_DTR_OP,
    input  wire [7:0] I_NONVOLATILE_CONFIG_REG,
    input  wire       I_VOLATILE_ENHANCED_CONFIG_REG_WE,
    input  wire [7:0] I_VOLATILE_ENHANCED_CONFIG_REG_WDATA,
    input  wire       I_DQ3_RST_DIS,
    input  wire [3:0] I_BP,
    input  wire       I_PROG_LAST,
    input  wire       I_OP_DONE,
    input  wire [7:0] I_TX_DATA,
    input  wire       I_TX_VALID,
    output reg        O_TX_READY,
    output reg  [7:0] O_RX_DATA,
    output reg        O_RX_VALID,
    input  wire       I_RX_READY,
    output reg  [3:0] O_DQ_OUT,
    output reg  [3:0] O_DQ_OE,
    output reg  [3:0] O_DQ_IN_EN,
    output reg  [7:0] O_VOLATILE_ENHANCED_CONFIG_REG,
    output reg        O_HOLD_ACTIVE,
    output reg        O_DEV_RESET,
    output reg  [3:0] O_WP_LOCK,
    output reg  [1:0] O_ACC_STATE,
    output reg  [1:0] O_PROTO_EFF
);

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg  [7:0] s1_r;
reg  [7:0] s2_r;
reg  [7:0] s3_r;
reg  [7:0] pin_r;
wire [7:0] pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
reg        clk_d_r;
reg        csn_d_r;

always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
        s1_r    <= `SFP_PIN_RSTV;
        s2_r    <= `SFP_PIN_RSTV;
        s3_r    <= `SFP_PIN_RSTV;
        pin_r   <= `SFP_PIN_RSTV;
        clk_d_r <= 1'b0;
        csn_d_r <= 1'b1;
    end else begin
        s1_r    <= {I_DQ_IN, I_VPP_HIGH, I_RESET_PIN_N, I_CS_N, I_SCLK};
        s2_r    <= s1_r;
        s3_r    <= s2_r;
        pin_r   <= pin_nxt;
        clk_d_r <= pin_r[`SFP_PIN_CLK];
        csn_d_r <= pin_r[`SFP_PIN_CSN];
    end
end

wire       sck    = pin_r[`SFP_PIN_CLK];
wire       csn    = pin_r[`SFP_PIN_CSN];
wire [3:0] dq     = pin_r[`SFP_PIN_DQ0 +: 4];
wire       rise   = sck & ~clk_d_r;
wire       fall   = ~sck & clk_d_r;
wire       cs_on  = csn_d_r & ~csn;
wire       cs_off = csn & ~csn_d_r;

// ----------------------------------------
// line roles
// ----------------------------------------
reg  [1:0] ac_r;
reg        dtr_r;
reg        armed_r;
wire       quad_cmd = (I_CMD_CLASS == `SFP_CMD_QOUT) | (I_CMD_CLASS == `SFP_CMD_QIN);
wire       dual_cmd = (I_CMD_CLASS == `SFP_CMD_DOUT) | (I_CMD_CLASS == `SFP_CMD_DIN);
wire       fallback = (ac_r == `SFP_AC_FAST);
wire       quad_p   = (I_PROTO == `SFP_PROTO_QUAD) & ~fallback;
wire       dual_p   = (I_PROTO == `SFP_PROTO_DUAL);
wire       line2_dat = quad_p | quad_cmd;
wire       line3_dat = quad_p | quad_cmd;
reg  [1:0] width;

always @* begin
    if (line3_dat)
        width = `SFP_PROTO_QUAD;
    else if (dual_p | dual_cmd)
        width = `SFP_PROTO_DUAL;
    else
        width = `SFP_PROTO_SINGLE;
end

wire cfg_hold_dis = ~I_NONVOLATILE_CONFIG_REG[`SFP_NONVOLATILE_CONFIG_REG_HOLD] | ~O_VOLATILE_ENHANCED_CONFIG_REG[`SFP_VOLATILE_ENHANCED_CONFIG_REG_HOLD];
wire hold_en = ~cfg_hold_dis & ~dtr_r & ~line3_dat;
wire hold = hold_en & ~csn & ~dq[3];
wire dq3_rst = (RST_CAPABLE != 0) & quad_p & csn & ~dq[3] & ~I_DQ3_RST_DIS;
wire dev_rst = ~pin_r[`SFP_PIN_RST] | dq3_rst;
// active only after a first select fall
wire active = ~csn & armed_r & ~hold & ~dev_rst;

always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
        dtr_r   <= 1'b0;
        armed_r <= 1'b0;
        O_VOLATILE_ENHANCED_CONFIG_REG  <= `SFP_VOLATILE_ENHANCED_CONFIG_REG_RSTV;
    end else begin
        if (cs_off | dev_rst)
            dtr_r <= 1'b0;
        else if (I_DTR_OP)
            dtr_r <= 1'b1;
        if (cs_on & ~dev_rst)
            armed_r <= 1'b1;
        // bit 3 back to 1 on reset
        if (dev_rst)
            O_VOLATILE_ENHANCED_CONFIG_REG <= `SFP_VOLATILE_ENHANCED_CONFIG_REG_RSTV;
        else if (I_VOLATILE_ENHANCED_CONFIG_REG_WE)
            O_VOLATILE_ENHANCED_CONFIG_REG <= I_VOLATILE_ENHANCED_CONFIG_REG_WDATA;
    end
end

// ----------------------------------------
// supply acceleration
// ----------------------------------------
reg  [31:0] acc_cnt_r;
reg  [1:0]  ac_nxt;
// enabled only with bit 3 clear
wire acc_ok = ~O_VOLATILE_ENHANCED_CONFIG_REG[`SFP_VOLATILE_ENHANCED_CONFIG_REG_ACC] & ((I_CMD_CLASS == `SFP_CMD_QIN) | quad_p);
wire vpp = pin_r[`SFP_PIN_VPP];

always @* begin
    ac_nxt = ac_r;
    case (ac_r)
    `SFP_AC_IDLE: begin
        if (I_PROG_LAST & acc_ok)
            ac_nxt = `SFP_AC_WAIT;
    end
    // wait for the supply, else slow
    `SFP_AC_WAIT: begin
        if (vpp)
            ac_nxt = `SFP_AC_FAST;
        else if (acc_cnt_r >= ACC_WAIT_CYC - 32'h1)
            ac_nxt = `SFP_AC_SLOW;
    end
    `SFP_AC_FAST: begin
        if (!vpp)
            ac_nxt = `SFP_AC_IDLE;
    end
    default: begin
        if (I_OP_DONE)
            ac_nxt = `SFP_AC_IDLE;
    end
    endcase
end

always @(posedge I_CLOCK) begin
    if (!I_RST_N | dev_rst) begin
        ac_r      <= `SFP_AC_IDLE;
        acc_cnt_r <= 32'h0;
    end else begin
        ac_r      <= ac_nxt;
        acc_cnt_r <= (ac_r == `SFP_AC_WAIT) ? acc_cnt_r + 32'h1 : 32'h0;
    end
end

// ----------------------------------------
// two-entry transmit buffer
// ----------------------------------------
reg  [7:0] buf0_r;
reg  [7:0] buf1_r;
reg  [1:0] cnt_r;
reg  [2:0] obit_r;
reg  [7:0] osh_r;
wire       push = I_TX_VALID & (cnt_r != 2'h2);
// a byte is pulled at the first fall of each output byte
wire       pull = active & I_OUT_PHASE & fall & (obit_r == 3'h0) & (cnt_r != 2'h0);

always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
        buf0_r     <= 8'h00;
        buf1_r     <= 8'h00;
        cnt_r      <= 2'h0;
        O_TX_READY <= 1'b0;
    end else begin
        if (pull) begin
            buf0_r <= (cnt_r == 2'h2) ? buf1_r : (push ? I_TX_DATA : buf0_r);
            if (push & (cnt_r == 2'h2))
                buf1_r <= I_TX_DATA;
            cnt_r <= push ? cnt_r : cnt_r - 2'h1;
        end else if (push) begin
            if (cnt_r == 2'h0)
                buf0_r <= I_TX_DATA;
            else
                buf1_r <= I_TX_DATA;
            cnt_r <= cnt_r + 2'h1;
        end
        O_TX_READY <= (cnt_r == 2'h0) | ((cnt_r == 2'h1) & ~push) | pull;
    end
end

// ----------------------------------------
// shifters
// ----------------------------------------
reg  [7:0] ish_r;
reg  [2:0] ibit_r;
reg  [2:0] step;
reg  [7:0] ish_nxt;
reg  [7:0] ld;
reg  [7:0] osh_nxt;
reg  [3:0] oe_nxt;
reg  [3:0] out_nxt;

always @* begin
    step    = 3'h1;
    ish_nxt = {ish_r[6:0], dq[0]};
    // line 1 becomes input for wide programs
    if (width == `SFP_PROTO_QUAD) begin
        step    = 3'h4;
        ish_nxt = {ish_r[3:0], dq};
    end else if (width == `SFP_PROTO_DUAL) begin
        step    = 3'h2;
        ish_nxt = {ish_r[5:0], dq[1:0]};
    end
    ld      = (obit_r == 3'h0) ? buf0_r : osh_r;
    osh_nxt = ld << step;
    oe_nxt  = `SFP_OE_W1;
    out_nxt = {2'h0, ld[7], 1'b0};
    if (width == `SFP_PROTO_QUAD) begin
        oe_nxt  = `SFP_OE_W4;
        out_nxt = ld[7:4];
    end else if (width == `SFP_PROTO_DUAL) begin
        oe_nxt  = `SFP_OE_W2;
        out_nxt = {2'h0, ld[7:6]};
    end
end

always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
        ish_r      <= 8'h00;
        ibit_r     <= 3'h0;
        osh_r      <= 8'h00;
        obit_r     <= 3'h0;
        O_RX_DATA  <= 8'h00;
        O_RX_VALID <= 1'b0;
        O_DQ_OUT   <= 4'h0;
        O_DQ_OE    <= 4'h0;
        O_DQ_IN_EN <= 4'hF;
    end else begin
        if (O_RX_VALID & I_RX_READY)
            O_RX_VALID <= 1'b0;
        if (~active & ~hold) begin
            ibit_r <= 3'h0;
            obit_r <= 3'h0;
        end
        if (active & ~I_OUT_PHASE & rise) begin
            ish_r  <= ish_nxt;
            ibit_r <= ibit_r + step;
            if (ibit_r + step == 3'h0) begin
                O_RX_DATA  <= ish_nxt;
                O_RX_VALID <= 1'b1;
            end
        end
        if (active & I_OUT_PHASE & fall) begin
            osh_r    <= osh_nxt;
            obit_r   <= obit_r + step;
            O_DQ_OUT <= out_nxt;
        end
        if (active & I_OUT_PHASE) begin
            O_DQ_OE    <= oe_nxt;
            O_DQ_IN_EN <= ~oe_nxt;
        end else begin
            O_DQ_OE    <= 4'h0;
            O_DQ_IN_EN <= 4'hF;
        end
    end
end

// ----------------------------------------
// status
// ----------------------------------------
always @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
        O_HOLD_ACTIVE <= 1'b0;
        O_DEV_RESET   <= 1'b0;
        O_WP_LOCK     <= 4'h0;
        O_ACC_STATE   <= `SFP_AC_IDLE;
        O_PROTO_EFF   <= `SFP_PROTO_SINGLE;
    end else begin
        O_HOLD_ACTIVE <= hold;
        O_DEV_RESET   <= dev_rst;
        // write-protect lock, not when line 2 is data
        O_WP_LOCK     <= (~line2_dat & ~dq[2]) ? I_BP : 4'h0;
        O_ACC_STATE   <= ac_r;
        O_PROTO_EFF   <= width;
    end
end

endmodule // sfp_pin_roles

// ---- hw/sfp_defines.vh ----
// constants for the serial flash pin-role block
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH
// protocol select
`define SFP_PROTO_SINGLE 2'h0
`define SFP_PROTO_DUAL   2'h1
`define SFP_PROTO_QUAD   2'h2
// command class of the running command
`define SFP_CMD_IDLE  3'h0
`define SFP_CMD_READ1 3'h1
`define SFP_CMD_DOUT  3'h2
`define SFP_CMD_QOUT  3'h3
`define SFP_CMD_DIN   3'h4
`define SFP_CMD_QIN   3'h5
`define SFP_CMD_OTHER 3'h6
// synchroniser vector: {dq3..dq0, vpp, reset, cs_n, clock}
`define SFP_PIN_CLK   0
`define SFP_PIN_CSN   1
`define SFP_PIN_RST   2
`define SFP_PIN_VPP   3
`define SFP_PIN_DQ0   4
`define SFP_PIN_RSTV  8'h06
// volatile enhanced and nonvolatile configuration bits
`define SFP_VOLATILE_ENHANCED_CONFIG_REG_ACC  3
`define SFP_VOLATILE_ENHANCED_CONFIG_REG_HOLD 4
`define SFP_VOLATILE_ENHANCED_CONFIG_REG_RSTV 8'hFF
`define SFP_NONVOLATILE_CONFIG_REG_HOLD 4
// line enables per width
`define SFP_OE_W1 4'h2
`define SFP_OE_W2 4'h3
`define SFP_OE_W4 4'hF
// acceleration wait
`define SFP_ACC_WAIT_MS 200
`define SFP_CLK_KHZ     50000
// accelerate state codes
`define SFP_AC_IDLE 2'h0
`define SFP_AC_WAIT 2'h1
`define SFP_AC_FAST 2'h2
`define SFP_AC_SLOW 2'h3
`endif

// ---- verification/sfp_host_model.sv ----
// host-side model driving the serial flash lines
`timescale 1ns/100ps
module sfp_host_model (
    input  wire       clk,
    input  wire [3:0] oe,
    input  wire [3:0] dout,
    output reg        sclk,
    output reg        cs_n,
    output reg  [3:0] dq,
    output wire [3:0] pin
);
    integer k;
    assign pin = (oe & dout) | (~oe & dq);
    // clock idles high so every bit starts with a fall
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        dq = 4'hF;
    end
    // data set after fall, read after rise
    task xfer(input [7:0] tx, input rd, output [7:0] rx);
        for (k = 7; k >= 0; k = k - 1) begin
            @(posedge clk) sclk <= 1'b0;
            // released line toggles so no stale level survives
            dq[0] <= rd ? ~dq[0] : tx[k];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            rx[k] = pin[1];
        end
    endtask
endmodule // sfp_host_model

// ---- verification/sfp_pin_roles_sva.sv ----
// port assertions of the pin-role block
`timescale 1ns/100ps
`include "sfp_defines.vh"
module sfp_pin_roles_sva (
    input wire       I_CLOCK,
    input wire       I_RST_N,
    input wire       I_CS_N,
    input wire [1:0] I_PROTO,
    input wire [2:0] I_CMD_CLASS,
    input wire       I_OUT_PHASE,
    input wire [7:0] I_NONVOLATILE_CONFIG_REG,
    input wire [3:0] O_DQ_OE,
    input wire [3:0] O_DQ_IN_EN,
    input wire [7:0] O_VOLATILE_ENHANCED_CONFIG_REG,
    input wire       O_HOLD_ACTIVE,
    input wire       O_DEV_RESET,
    input wire [1:0] O_ACC_STATE
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    a_rx_en_inverse: assert property (O_DQ_IN_EN == ~O_DQ_OE)
        else $error("receiver enable wrong");
    a_idle_no_drive: assert property (!$past(I_OUT_PHASE) |-> O_DQ_OE == 4'h0)
        else $error("drive outside output phase");
    a_single_read_oe: assert property ($past(I_OUT_PHASE && I_CMD_CLASS == `SFP_CMD_READ1
        && I_PROTO == `SFP_PROTO_SINGLE) |-> O_DQ_OE inside {4'h0, `SFP_OE_W1})
        else $error("single read drive wrong");
    a_hold_floats: assert property (O_HOLD_ACTIVE [*2] |-> O_DQ_OE == 4'h0)
        else $error("drive during pause");
    a_hold_cfg_off: assert property (!$past(I_NONVOLATILE_CONFIG_REG[4] && O_VOLATILE_ENHANCED_CONFIG_REG[4]) |-> !O_HOLD_ACTIVE)
        else $error("pause while disabled");
    a_hold_quad_off: assert property ($past(I_PROTO) == `SFP_PROTO_QUAD && O_ACC_STATE != `SFP_AC_FAST
        |-> !O_HOLD_ACTIVE)
        else $error("pause in quad protocol");
    a_desel_float: assert property (I_CS_N [*8] |-> O_DQ_OE == 4'h0)
        else $error("drive while deselected");
    a_devrst_float: assert property (O_DEV_RESET |-> O_DQ_OE == 4'h0 && O_VOLATILE_ENHANCED_CONFIG_REG == 8'hFF)
        else $error("device reset not applied");
    a_acc_gate: assert property ($past(O_VOLATILE_ENHANCED_CONFIG_REG[3], 2) && $past(O_ACC_STATE) == `SFP_AC_IDLE
        |-> O_ACC_STATE == `SFP_AC_IDLE)
        else $error("acceleration while gated");
endmodule // sfp_pin_roles_sva
bind sfp_pin_roles sfp_pin_roles_sva u_sva (.I_CLOCK, .I_RST_N, .I_CS_N, .I_PROTO, .I_CMD_CLASS,
    .I_OUT_PHASE, .I_NONVOLATILE_CONFIG_REG, .O_DQ_OE, .O_DQ_IN_EN, .O_VOLATILE_ENHANCED_CONFIG_REG, .O_HOLD_ACTIVE, .O_DEV_RESET, .O_ACC_STATE);

// ---- verification/sfp_pin_roles_test.sv ----
// self-checking bench of the pin-role block
`timescale 1ns/100ps
`include "sfp_defines.vh"
module sfp_pin_roles_test;
    reg        clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        rpin_n = 1'b1;
    reg  [1:0] proto = `SFP_PROTO_SINGLE;
    reg  [2:0] cls = `SFP_CMD_IDLE;
    reg        oph = 1'b0;
    reg  [7:0] nonvolatile_config_reg = 8'hFF;
    reg        vwe = 1'b0;
    reg  [7:0] vwd = 8'hFF;
    reg        pl = 1'b0;
    reg        done = 1'b0;
    reg  [7:0] txd = 8'h00;
    reg        txv = 1'b0;
    reg        rxr = 1'b0;
    reg        vpp = 1'b0;
    reg        dtr = 1'b0;
    reg  [7:0] rx;
    integer    n_errors = 0;
    integer    tests_run = 0;
    wire       sclk, cs_n, trdy, rxv, hold, drst;
    wire [3:0] pin, dqo, oe, ien, wp;
    wire [7:0] rxd, volatile_enhanced_config_reg;
    wire [1:0] acc, peff;
    always #10 clk = ~clk;
    sfp_host_model h (.clk(clk), .oe(oe), .dout(dqo), .sclk(sclk), .cs_n(cs_n), .dq(), .pin(pin));
    sfp_pin_roles #(.ACC_WAIT_CYC(32'd50)) dut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
        .I_RESET_PIN_N(rpin_n), .I_VPP_HIGH(vpp), .I_DQ_IN(pin), .I_PROTO(proto),
        .I_CMD_CLASS(cls), .I_OUT_PHASE(oph), .I_DTR_OP(dtr), .I_NONVOLATILE_CONFIG_REG(nonvolatile_config_reg),
        .I_VOLATILE_ENHANCED_CONFIG_REG_WE(vwe), .I_VOLATILE_ENHANCED_CONFIG_REG_WDATA(vwd), .I_DQ3_RST_DIS(1'b0), .I_BP(4'h5),
        .I_PROG_LAST(pl), .I_OP_DONE(done), .I_TX_DATA(txd), .I_TX_VALID(txv),
        .O_TX_READY(trdy), .O_RX_DATA(rxd), .O_RX_VALID(rxv), .I_RX_READY(rxr),
        .O_DQ_OUT(dqo), .O_DQ_OE(oe), .O_DQ_IN_EN(ien), .O_VOLATILE_ENHANCED_CONFIG_REG(volatile_enhanced_config_reg),
        .O_HOLD_ACTIVE(hold), .O_DEV_RESET(drst), .O_WP_LOCK(wp),
        .O_ACC_STATE(acc), .O_PROTO_EFF(peff));
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("Error %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task end_sim;
        begin
            if (n_errors == 0 && tests_run > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task push(input [7:0] d);
        begin
            @(posedge clk) txd <= d;
            txv <= 1'b1;
            @(posedge clk);
            while (trdy !== 1'b1) @(posedge clk);
            txv <= 1'b0;
        end
    endtask
    task t_write;
        begin
            h.cs_n <= 1'b0;
            cyc(8);
            h.xfer(8'hA5, 1'b0, rx);
            cyc(8);
            chk("rxv", 8'h01, rxv);
            chk("rxd", 8'hA5, rxd);
            rxr <= 1'b1;
            cyc(1);
            rxr <= 1'b0;
            cyc(2);
            chk("rxv", 8'h00, rxv);
        end
    endtask
    task t_read;
        begin
            push(8'h3C);
            push(8'hC3);
            cyc(2);
            chk("trdy", 8'h00, trdy);
            cls <= `SFP_CMD_READ1;
            oph <= 1'b1;
            cyc(2);
            chk("oe", `SFP_OE_W1, oe);
            h.xfer(8'h00, 1'b1, rx);
            chk("rd0", 8'h3C, rx);
            h.xfer(8'h00, 1'b1, rx);
            chk("rd1", 8'hC3, rx);
            oph <= 1'b0;
            cls <= `SFP_CMD_IDLE;
            cyc(2);
            chk("oe", 8'h00, oe);
            chk("trdy", 8'h01, trdy);
        end
    endtask
    task t_hold;
        begin
            h.dq[3] <= 1'b0;
            cyc(8);
            chk("hold", 8'h01, hold);
            chk("oe", 8'h00, oe);
            nonvolatile_config_reg <= 8'hEF;
            cyc(2);
            chk("hold", 8'h00, hold);
            nonvolatile_config_reg <= 8'hFF;
            proto <= `SFP_PROTO_QUAD;
            cyc(2);
            chk("hold", 8'h00, hold);
            proto <= `SFP_PROTO_SINGLE;
            dtr <= 1'b1;
            cyc(1);
            dtr <= 1'b0;
            cyc(2);
            chk("hold", 8'h00, hold);
            h.dq[3] <= 1'b1;
            cyc(8);
        end
    endtask
    task t_wp;
        begin
            h.dq[2] <= 1'b0;
            cyc(8);
            chk("wp", 8'h05, wp);
            proto <= `SFP_PROTO_QUAD;
            cyc(3);
            chk("wp", 8'h00, wp);
            chk("peff", `SFP_PROTO_QUAD, peff);
            proto <= `SFP_PROTO_SINGLE;
            h.dq[2] <= 1'b1;
            cyc(8);
        end
    endtask
    task t_acc;
        begin
            vwd <= 8'hF7;
            vwe <= 1'b1;
            cyc(1);
            vwe <= 1'b0;
            proto <= `SFP_PROTO_QUAD;
            cls <= `SFP_CMD_QIN;
            cyc(2);
            pl <= 1'b1;
            cyc(1);
            pl <= 1'b0;
            cyc(3);
            chk("acc", `SFP_AC_WAIT, acc);
            cyc(48);
            chk("acc", `SFP_AC_WAIT, acc);
            cyc(1);
            chk("acc", `SFP_AC_SLOW, acc);
            done <= 1'b1;
            cyc(1);
            done <= 1'b0;
            cls <= `SFP_CMD_IDLE;
            proto <= `SFP_PROTO_SINGLE;
            cyc(3);
            chk("acc", `SFP_AC_IDLE, acc);
            // supply present: single-line fallback until it drops
            proto <= `SFP_PROTO_QUAD;
            cls <= `SFP_CMD_QIN;
            pl <= 1'b1;
            cyc(1);
            pl <= 1'b0;
            cls <= `SFP_CMD_IDLE;
            vpp <= 1'b1;
            cyc(8);
            chk("acc", `SFP_AC_FAST, acc);
            chk("peff", `SFP_PROTO_SINGLE, peff);
            vpp <= 1'b0;
            cyc(8);
            chk("acc", `SFP_AC_IDLE, acc);
            chk("peff", `SFP_PROTO_QUAD, peff);
            proto <= `SFP_PROTO_SINGLE;
            cyc(2);
        end
    endtask
    task t_rstpin;
        begin
            chk("volatile_enhanced_config_reg", 8'hF7, volatile_enhanced_config_reg);
            // reset pin pulsed only while no modify runs
            rpin_n <= 1'b0;
            cyc(8);
            chk("drst", 8'h01, drst);
            chk("volatile_enhanced_config_reg", 8'hFF, volatile_enhanced_config_reg);
            chk("oe", 8'h00, oe);
            rpin_n <= 1'b1;
            cyc(8);
            chk("drst", 8'h00, drst);
            h.cs_n <= 1'b1;
            proto <= `SFP_PROTO_QUAD;
            h.dq[3] <= 1'b0;
            cyc(8);
            chk("drst", 8'h01, drst);
            h.dq[3] <= 1'b1;
            proto <= `SFP_PROTO_SINGLE;
            cyc(8);
            chk("drst", 8'h00, drst);
        end
    endtask
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        end_sim;
    end
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        cyc(4);
        chk("volatile_enhanced_config_reg", 8'hFF, volatile_enhanced_config_reg);
        chk("ien", 8'h0F, ien);
        chk("trdy", 8'h01, trdy);
        t_write;
        t_read;
        t_hold;
        t_wp;
        t_acc;
        t_rstpin;
        end_sim;
    end
endmodule // sfp_pin_roles_test
